/* File: rtl/uebr_regs.sv */
// Design decision made here: register access over APB.
`timescale 1ns/1ns
`default_nettype none
module uebr_regs #(
    parameter int COUNT_W = uebr_pkg::COUNT_W
) (
    // apb slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    // endpoint events, one-cycle pulses or levels
    input wire logic clear_feature_evt,
    input wire logic bus_error_evt,
    input wire logic dma_done_evt,
    input wire logic alt_setting_evt,
    input wire logic token_evt,
    input wire logic stall_evt,
    // register contents towards the endpoint dma
    output logic [31:0] ep_dma_start_address,
    output logic [COUNT_W-1:0] ep_dma_byte_count,
    output logic [5:0] ep_event_enable,
    output logic ep_irq
);

    // ************************************************************
    // parameter check
    // ************************************************************
    generate
        if (COUNT_W < 1 || COUNT_W > 32) begin : g_bad_count
            $error("uebr_regs byte count width must lie in 1..32");
        end
    endgenerate

    // ************************************************************
    // declarations
    // ************************************************************
    uebr_evt_if evt_link ();

    uebr_pkg::uebr_apb_state_type state_reg;
    uebr_pkg::uebr_apb_state_type state_next;

    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;
    logic pslverr_reg;
    logic pslverr_next;

    logic setup_phase;
    logic access_phase;
    logic write_commit;
    logic hit_enable;
    logic hit_clear;
    logic hit_status;
    logic hit_dma_addr;
    logic hit_dma_count;
    logic hit_any;
    logic write_to_ro;

    logic [5:0] raw_events;
    logic [5:0] clear_mask;
    logic [5:0] ep_event_status_reg;
    logic [5:0] pending_enabled;
    logic [31:0] status_word;
    logic [31:0] enable_word;
    logic [31:0] count_word;
    logic [31:0] read_word;

    logic wr_enable;
    logic wr_dma_addr;
    logic wr_dma_count;

    // ************************************************************
    // decode helpers
    // ************************************************************

    // word match of a bus address against a register address
    function automatic logic addr_hit(
        input logic [31:0] addr,
        input logic [31:0] reg_addr
    );
        addr_hit = (addr[31:2] == reg_addr[31:2]);
    endfunction : addr_hit

    // widen a low field to a full bus word, upper bits zero
    function automatic logic [31:0] zext6(input logic [5:0] field);
        zext6 = {26'h000_0000, field};
    endfunction : zext6

    // ************************************************************
    // apb phase tracking
    // ************************************************************

    // phase flags of the current transfer
    assign setup_phase = psel && !penable;
    assign access_phase = psel && penable;
    assign write_commit = access_phase && pready && pwrite &&
        state_reg == uebr_pkg::APB_SETUP;

    // state follows the bus phases; a write commits only after a setup
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            uebr_pkg::APB_IDLE: begin
                if (setup_phase) begin
                    state_next = uebr_pkg::APB_SETUP;
                end
            end
            uebr_pkg::APB_SETUP: begin
                if (access_phase) begin
                    state_next = uebr_pkg::APB_ACCESS;
                end else if (!psel) begin
                    state_next = uebr_pkg::APB_IDLE;
                end
            end
            uebr_pkg::APB_ACCESS: begin
                if (setup_phase) begin
                    state_next = uebr_pkg::APB_SETUP;
                end else begin
                    state_next = uebr_pkg::APB_IDLE;
                end
            end
            default: begin
                state_next = uebr_pkg::APB_IDLE;
            end
        endcase
    end

    // phase state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= uebr_pkg::APB_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // zero wait state: the access phase always completes at once
    assign pready = 1'b1;

    // ************************************************************
    // address decode
    // ************************************************************

    // one hit line per mapped word
    assign hit_enable = addr_hit(paddr, uebr_pkg::ENABLE_ADDR);
    assign hit_clear = addr_hit(paddr, uebr_pkg::CLEAR_ADDR);
    assign hit_status = addr_hit(paddr, uebr_pkg::STATUS_ADDR);
    assign hit_dma_addr = addr_hit(paddr, uebr_pkg::DMA_ADDR_ADDR);
    assign hit_dma_count = addr_hit(paddr, uebr_pkg::DMA_COUNT_ADDR);
    assign hit_any = hit_enable | hit_clear | hit_status |
        hit_dma_addr | hit_dma_count;

    // status is read-only, a write to it is answered with an error
    assign write_to_ro = pwrite && hit_status;

    // write strobes at the completing edge
    assign wr_enable = write_commit && hit_enable;
    assign wr_dma_addr = write_commit && hit_dma_addr;
    assign wr_dma_count = write_commit && hit_dma_count;

    // ************************************************************
    // event flags
    // ************************************************************

    // event inputs placed at their flag positions
    assign raw_events[uebr_pkg::CLEAR_FEATURE_BIT] = clear_feature_evt;
    assign raw_events[uebr_pkg::BUS_ERROR_BIT] = bus_error_evt;
    assign raw_events[uebr_pkg::DMA_DONE_BIT] = dma_done_evt;
    assign raw_events[uebr_pkg::ALT_SETTING_BIT] = alt_setting_evt;
    assign raw_events[uebr_pkg::TOKEN_BIT] = token_evt;
    assign raw_events[uebr_pkg::STALL_BIT] = stall_evt;

    // ones written to the clear word, byte lane 0 carries all of them
    assign clear_mask = (write_commit && hit_clear && pstrb[0]) ?
        pwdata[5:0] : 6'h00;

    // set and clear go to the sticky store
    assign evt_link.evt_set = raw_events;
    assign evt_link.evt_clr = clear_mask;
    assign ep_event_status_reg = evt_link.evt_flags;

    uebr_event_flags u_flags (
        .pclk(pclk),
        .presetn(presetn),
        .evt(evt_link.store)
    );

    // ************************************************************
    // read/write registers
    // ************************************************************

    // interrupt enables, one per flag
    uebr_rw_reg #(
        .WIDTH(uebr_pkg::EVT_W),
        .RESET_VALUE({26'h000_0000, uebr_pkg::ENABLE_RESET})
    ) u_enable (
        .pclk(pclk),
        .presetn(presetn),
        .wr_en(wr_enable),
        .wr_strb(pstrb),
        .wr_data(pwdata),
        .q(ep_event_enable)
    );

    // dma memory start address, all 32 bits
    uebr_rw_reg #(
        .WIDTH(32),
        .RESET_VALUE(uebr_pkg::DMA_ADDR_RESET)
    ) u_dma_addr (
        .pclk(pclk),
        .presetn(presetn),
        .wr_en(wr_dma_addr),
        .wr_strb(pstrb),
        .wr_data(pwdata),
        .q(ep_dma_start_address)
    );

    // dma transfer byte count, low field only
    uebr_rw_reg #(
        .WIDTH(COUNT_W),
        .RESET_VALUE(uebr_pkg::DMA_COUNT_RESET)
    ) u_dma_count (
        .pclk(pclk),
        .presetn(presetn),
        .wr_en(wr_dma_count),
        .wr_strb(pstrb),
        .wr_data(pwdata),
        .q(ep_dma_byte_count)
    );

    // ************************************************************
    // read path
    // ************************************************************

    // words as software sees them, reserved bits zero
    assign status_word = zext6(ep_event_status_reg);
    assign enable_word = zext6(ep_event_enable);
    assign count_word = 32'(ep_dma_byte_count);

    // read selection; clear word and unmapped words read zero
    assign read_word = hit_status ? status_word :
        hit_enable ? enable_word :
        hit_dma_addr ? ep_dma_start_address :
        hit_dma_count ? count_word :
        32'h0000_0000;

    // capture answer in the setup cycle so it stands from a flop
    always_comb begin
        prdata_next = prdata_reg;
        pslverr_next = pslverr_reg;
        if (setup_phase) begin
            prdata_next = pwrite ? 32'h0000_0000 : read_word;
            pslverr_next = !hit_any || write_to_ro;
        end
    end

    // answer registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end else begin
            prdata_reg <= prdata_next;
            pslverr_reg <= pslverr_next;
        end
    end

    assign prdata = prdata_reg;
    assign pslverr = pslverr_reg && access_phase; // only shown in access

    // ************************************************************
    // interrupt
    // ************************************************************

    // pending flags that software has enabled
    assign pending_enabled = ep_event_status_reg & ep_event_enable;
    assign ep_irq = |pending_enabled;

endmodule : uebr_regs
`default_nettype wire

/* File: rtl/uebr_pkg.sv */
// Notes on behaviour
// - event status word reads flags in bits 5..0, upper bits zero, resets zero
// - write-only clear word; each one written clears the matching pending flag; here only with byte lane 0 strobed, and a set in the same cycle wins
// - bit 5 set by host clear-feature, held until software clears bit 5
// - bit 4 set on endpoint dma system bus error, cleared by bit 4
// - bit 3 set when dma finishes its programmed transfer, cleared by bit 3
// - bit 2 set on host alternate setting change, cleared by bit 2
// - bit 1 set on token addressed to endpoint, cleared by bit 1
// - bit 0 set on endpoint stall condition, cleared by bit 0
// - dma start address is a full 32-bit read/write word resetting to zero
// - dma byte count is 20-bit read/write in bits 19..0, rest zero
// - enable word holds one interrupt enable per flag at bits 5..0
package uebr_pkg;

    // ************************************************************
    // register byte addresses
    // ************************************************************
    localparam logic [31:0] ENABLE_ADDR = 32'hFFF0_606C;
    localparam logic [31:0] CLEAR_ADDR = 32'hFFF0_6070;
    localparam logic [31:0] STATUS_ADDR = 32'hFFF0_6074;
    localparam logic [31:0] DMA_ADDR_ADDR = 32'hFFF0_6078;
    localparam logic [31:0] DMA_COUNT_ADDR = 32'hFFF0_607C;

    // ************************************************************
    // field layout and reset values
    // ************************************************************
    localparam int EVT_W = 6;
    localparam int COUNT_W = 20;
    localparam int CLEAR_FEATURE_BIT = 5;
    localparam int BUS_ERROR_BIT = 4;
    localparam int DMA_DONE_BIT = 3;
    localparam int ALT_SETTING_BIT = 2;
    localparam int TOKEN_BIT = 1;
    localparam int STALL_BIT = 0;
    localparam logic [5:0] EVT_RESET = 6'h00;
    localparam logic [5:0] ENABLE_RESET = 6'h00;
    localparam logic [31:0] DMA_ADDR_RESET = 32'h0000_0000;
    localparam logic [31:0] DMA_COUNT_RESET = 32'h0000_0000;

    // ************************************************************
    // bus slave states
    // ************************************************************
    typedef enum logic [1:0] {
        APB_IDLE = 2'b00,
        APB_SETUP = 2'b01,
        APB_ACCESS = 2'b10
    } uebr_apb_state_type;

endpackage : uebr_pkg

/* File: rtl/uebr_evt_if.sv */
`timescale 1ns/1ns
`default_nettype none
// event flag bank link between register front end and flag store
interface uebr_evt_if;
    logic [5:0] evt_set;
    logic [5:0] evt_clr;
    logic [5:0] evt_flags;

    modport regs (
        output evt_set,
        output evt_clr,
        input evt_flags
    );

    modport store (
        input evt_set,
        input evt_clr,
        output evt_flags
    );
endinterface : uebr_evt_if
`default_nettype wire

/* File: rtl/uebr_event_flags.sv */
`timescale 1ns/1ns
`default_nettype none
module uebr_event_flags (
    input wire logic pclk,
    input wire logic presetn,
    uebr_evt_if.store evt
);

    logic [5:0] flag_reg;
    logic [5:0] flag_next;

    // ************************************************************
    // sticky flags, a set in the clearing cycle wins
    // ************************************************************
    genvar i;
    generate
        for (i = 0; i < uebr_pkg::EVT_W; i++) begin : g_flag
            assign flag_next[i] = evt.evt_set[i] |
                (flag_reg[i] & ~evt.evt_clr[i]);
        end
    endgenerate

    // flag storage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_reg <= uebr_pkg::EVT_RESET;
        end else begin
            flag_reg <= flag_next;
        end
    end

    assign evt.evt_flags = flag_reg;

endmodule : uebr_event_flags
`default_nettype wire

/* File: rtl/uebr_rw_reg.sv */
`timescale 1ns/1ns
`default_nettype none
module uebr_rw_reg #(
    parameter int WIDTH = 32,
    parameter logic [31:0] RESET_VALUE = 32'h0000_0000
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic wr_en,
    input wire logic [3:0] wr_strb,
    input wire logic [31:0] wr_data,
    output logic [WIDTH-1:0] q
);

    // ************************************************************
    // width check
    // ************************************************************
    generate
        if (WIDTH < 1 || WIDTH > 32) begin : g_bad_width
            $error("uebr_rw_reg width must lie in 1..32");
        end
    endgenerate

    logic [WIDTH-1:0] q_reg;
    logic [WIDTH-1:0] q_next;

    // byte lane gated update of each bit
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            assign q_next[i] = (wr_en && wr_strb[i / 8]) ? wr_data[i] :
                q_reg[i];
        end
    endgenerate

    // register storage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q_reg <= RESET_VALUE[WIDTH-1:0];
        end else begin
            q_reg <= q_next;
        end
    end

    assign q = q_reg;

endmodule : uebr_rw_reg
`default_nettype wire

/* File: verification/uebr_regs_assertions.sv */
`timescale 1ns/1ns
`default_nettype none
// ************************************************************
// endpoint event and dma register checker
// ************************************************************
module uebr_regs_assertions #(
    parameter int COUNT_W = 20
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    input wire logic token_evt,
    input wire logic stall_evt,
    input wire logic [31:0] ep_dma_start_address,
    input wire logic [COUNT_W-1:0] ep_dma_byte_count,
    input wire logic [5:0] ep_event_enable,
    input wire logic ep_irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // write access phase
    wire wr_acc = psel && penable && pwrite;

    // read setup at one address, then its access phase
    sequence rd_at(logic [31:0] a);
        psel && !penable && !pwrite && paddr == a ##1 psel && penable;
    endsequence

    // bus refusals and read-back shape
    a_status_write_err: assert property (
        wr_acc && paddr == uebr_pkg::STATUS_ADDR |-> pslverr)
        else $error("status write not refused");
    a_status_upper_zero: assert property (
        rd_at(uebr_pkg::STATUS_ADDR) |-> prdata[31:6] == 26'h0)
        else $error("status reserved bits not zero");
    a_clear_reads_zero: assert property (
        rd_at(uebr_pkg::CLEAR_ADDR) |-> prdata == 32'h0)
        else $error("clear word read not zero");
    a_count_upper_zero: assert property (
        rd_at(uebr_pkg::DMA_COUNT_ADDR) |-> prdata[31:20] == 12'h0)
        else $error("count reserved bits not zero");
    // register updates at the write edge
    a_addr_write_full: assert property (
        wr_acc && paddr == uebr_pkg::DMA_ADDR_ADDR && pstrb == 4'hF
        |=> ep_dma_start_address == $past(pwdata))
        else $error("dma address not written");
    a_count_write_low: assert property (
        wr_acc && paddr == uebr_pkg::DMA_COUNT_ADDR && pstrb == 4'hF
        |=> ep_dma_byte_count == $past(pwdata[COUNT_W-1:0]))
        else $error("byte count not written");
    // event to interrupt relations
    a_token_irq: assert property (
        token_evt && ep_event_enable[1] && !wr_acc |=> ep_irq)
        else $error("token event gave no interrupt");
    a_stall_irq: assert property (
        stall_evt && ep_event_enable[0] && !wr_acc |=> ep_irq)
        else $error("stall event gave no interrupt");
    a_irq_needs_enable: assert property (
        ep_irq |-> ep_event_enable != 6'h00)
        else $error("interrupt without enable");
    a_irq_sticky_hold: assert property (
        ep_irq && !wr_acc |=> ep_irq)
        else $error("interrupt dropped without write");
endmodule : uebr_regs_assertions
`default_nettype wire

/* File: verification/uebr_far_end.sv */
`timescale 1ns/1ns
`default_nettype none
// ************************************************************
// host and dma side: one-cycle event pulses on command
// ************************************************************
module uebr_far_end (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [5:0] fire,
    output logic clear_feature_evt,
    output logic bus_error_evt,
    output logic dma_done_evt,
    output logic alt_setting_evt,
    output logic token_evt,
    output logic stall_evt
);
    logic [5:0] pulse_reg;

    // events launched one edge after the command
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pulse_reg <= 6'h00;
        end else begin
            pulse_reg <= fire;
        end
    end

    // bit order follows the status word
    assign {clear_feature_evt, bus_error_evt, dma_done_evt} = pulse_reg[5:3];
    assign {alt_setting_evt, token_evt, stall_evt} = pulse_reg[2:0];
endmodule : uebr_far_end
`default_nettype wire

/* File: verification/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
// ************************************************************
// endpoint register slice bench
// ************************************************************
module tb_top;
    typedef struct {
        logic [31:0] a;
        logic [31:0] d;
        logic [3:0] s;
        logic [31:0] x;
        logic e;
    } uebr_row_type;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ep_irq, er;
    logic [31:0] paddr, pwdata, prdata, ep_dma_start_address, rd;
    logic [3:0] pstrb;
    logic [5:0] fire, ep_event_enable;
    logic [19:0] ep_dma_byte_count;
    logic cf_evt, be_evt, dd_evt, as_evt, tk_evt, st_evt;
    int err_total, samples_checked;
    uebr_row_type rows [8];

    always #5 pclk = ~pclk;

    uebr_regs #(.COUNT_W(20)) DUT (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .clear_feature_evt(cf_evt),
        .bus_error_evt(be_evt), .dma_done_evt(dd_evt),
        .alt_setting_evt(as_evt), .token_evt(tk_evt), .stall_evt(st_evt),
        .ep_dma_start_address(ep_dma_start_address),
        .ep_dma_byte_count(ep_dma_byte_count),
        .ep_event_enable(ep_event_enable), .ep_irq(ep_irq));
    uebr_far_end u_far (.pclk(pclk), .presetn(presetn), .fire(fire),
        .clear_feature_evt(cf_evt), .bus_error_evt(be_evt),
        .dma_done_evt(dd_evt), .alt_setting_evt(as_evt),
        .token_evt(tk_evt), .stall_evt(st_evt));

    // compare and count
    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : wrap_up

    // one apb transfer, idle cycle first
    task automatic xfer(input logic [31:0] a, input logic w,
                        input logic [31:0] d, input logic [3:0] s);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            err_total++;
            wrap_up();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer

    // command far-end events and let the flags land
    task automatic fire_evt(input logic [5:0] v);
        @(posedge pclk);
        fire <= v;
        @(posedge pclk);
        fire <= 6'h00;
        repeat (3) @(posedge pclk);
    endtask : fire_evt

    task automatic irq_is(input logic x);
        @(negedge pclk);
        check("irq", {31'h0, ep_irq}, {31'h0, x});
    endtask : irq_is

    // main sequence
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata, pstrb, fire} = '0;
        err_total = 0;
        samples_checked = 0;
        rows = '{
        '{uebr_pkg::DMA_ADDR_ADDR, 32'hA5A5_5A5A, 4'hF, 32'hA5A5_5A5A, 1'b0},
        '{uebr_pkg::DMA_ADDR_ADDR, 32'h1234_5678, 4'h5, 32'hA534_5A78, 1'b0},
        '{uebr_pkg::DMA_COUNT_ADDR, 32'hFFFF_FFFF, 4'hF, 32'h000F_FFFF, 1'b0},
        '{uebr_pkg::DMA_COUNT_ADDR, 32'h1234_5678, 4'h3, 32'h000F_5678, 1'b0},
        '{uebr_pkg::ENABLE_ADDR, 32'hFFFF_FFFF, 4'hF, 32'h0000_003F, 1'b0},
        '{uebr_pkg::CLEAR_ADDR, 32'hFFFF_FFFF, 4'hF, 32'h0000_0000, 1'b0},
        '{uebr_pkg::STATUS_ADDR, 32'hFFFF_FFFF, 4'hF, 32'h0000_0000, 1'b1},
        '{32'hFFF0_6080, 32'h0000_0001, 4'hF, 32'h0000_0000, 1'b1}};
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            xfer(uebr_pkg::ENABLE_ADDR + 32'(4 * i), 1'b0, 32'h0, 4'h0);
            check("reset value", rd, 32'h0);
        end
        foreach (rows[i]) begin
            xfer(rows[i].a, 1'b1, rows[i].d, rows[i].s);
            check("write error", {31'h0, er}, {31'h0, rows[i].e});
            xfer(rows[i].a, 1'b0, 32'h0, 4'h0);
            check("readback", rd, rows[i].x);
        end
        // register contents as seen on the output ports
        check("addr", ep_dma_start_address, 32'hA534_5A78);
        check("cnt", {12'h000, ep_dma_byte_count}, 32'h000F_5678);
        check("enable", {26'h0, ep_event_enable}, 32'h0000_003F);
        for (int i = 0; i < 6; i++) begin
            fire_evt(6'(1 << i));
            xfer(uebr_pkg::STATUS_ADDR, 1'b0, 32'h0, 4'h0);
            check("flag", rd, 32'h1 << i);
            irq_is(1'b1);
            xfer(uebr_pkg::CLEAR_ADDR, 1'b1, 32'h1 << i, 4'hF);
            xfer(uebr_pkg::STATUS_ADDR, 1'b0, 32'h0, 4'h0);
            check("flag cleared", rd, 32'h0);
            irq_is(1'b0);
        end
        xfer(uebr_pkg::ENABLE_ADDR, 1'b1, 32'h0, 4'hF);
        fire_evt(6'h02);
        irq_is(1'b0);
        xfer(uebr_pkg::ENABLE_ADDR, 1'b1, 32'h2, 4'hF);
        irq_is(1'b1);
        xfer(uebr_pkg::CLEAR_ADDR, 1'b1, 32'h3F, 4'hE);
        xfer(uebr_pkg::STATUS_ADDR, 1'b0, 32'h0, 4'h0);
        check("lane gated clear", rd, 32'h2);
        // stall pulse lands at the edge that commits its clear
        fork
            xfer(uebr_pkg::CLEAR_ADDR, 1'b1, 32'h1, 4'hF);
            begin
                @(posedge pclk);
                fire <= 6'h01;
                @(posedge pclk);
                fire <= 6'h00;
            end
        join
        xfer(uebr_pkg::STATUS_ADDR, 1'b0, 32'h0, 4'h0);
        check("set beats clear", rd, 32'h3);
        xfer(uebr_pkg::DMA_ADDR_ADDR, 1'b1, 32'hFFFF_FFFF, 4'hF);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        xfer(uebr_pkg::DMA_ADDR_ADDR, 1'b0, 32'h0, 4'h0);
        check("address after reset", rd, 32'h0);
        xfer(uebr_pkg::STATUS_ADDR, 1'b0, 32'h0, 4'h0);
        check("status after reset", rd, 32'h0);
        irq_is(1'b0);
        wrap_up();
    end
endmodule : tb_top

bind uebr_regs uebr_regs_assertions #(.COUNT_W(COUNT_W)) u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pslverr(pslverr), .token_evt(token_evt),
    .stall_evt(stall_evt), .ep_dma_start_address(ep_dma_start_address),
    .ep_dma_byte_count(ep_dma_byte_count),
    .ep_event_enable(ep_event_enable), .ep_irq(ep_irq));
`default_nettype wire
